//--- hdl/cirp_pkg.sv
// package of constants and types for the interrupt recognition and priority unit
package cirp_pkg;
  // vector types
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_STEP = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  // vector table bounds, entry size as a log2 byte shift
  localparam logic [19:0] VEC_TABLE_BASE = 20'h00000;
  localparam logic [19:0] VEC_TABLE_TOP = 20'h003FF;
  localparam int VEC_ENTRY_SHIFT = 2;
  // vectoring step lengths in clocks
  localparam logic [3:0] LEN_IDLE0 = 4'h5;
  localparam logic [3:0] LEN_RD_PTR = 4'h4;
  localparam logic [3:0] LEN_IDLE1 = 4'h5;
  localparam logic [3:0] LEN_RD_SEG = 4'h4;
  localparam logic [3:0] LEN_IDLE2 = 4'h4;
  localparam logic [3:0] LEN_PUSH_FL = 4'h4;
  localparam logic [3:0] LEN_IDLE3 = 4'h3;
  localparam logic [3:0] LEN_PUSH_SEG = 4'h4;
  localparam logic [3:0] LEN_PUSH_PTR = 4'h4;
  localparam logic [3:0] LEN_IDLE4 = 4'h5;
  localparam int VECTOR_TOTAL_CLOCKS = 42;
  // longest instruction, clocks with zero-wait bus
  localparam int LONGEST_INSN_CLOCKS = 69;
  // status word bit positions
  localparam int FLAG_STEP_BIT = 8;
  localparam int FLAG_IE_BIT = 9;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_VEC = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // control register fields
  localparam int CTRL_IE_BIT = 0;
  localparam int CTRL_STEP_BIT = 1;
  localparam int CTRL_SWVEC_EN_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [10:0] {
    ST_IDLE0 = 11'b00000000001,
    ST_RD_PTR = 11'b00000000010,
    ST_IDLE1 = 11'b00000000100,
    ST_RD_SEG = 11'b00000001000,
    ST_IDLE2 = 11'b00000010000,
    ST_PUSH_FL = 11'b00000100000,
    ST_IDLE3 = 11'b00001000000,
    ST_PUSH_SEG = 11'b00010000000,
    ST_PUSH_PTR = 11'b00100000000,
    ST_IDLE4 = 11'b01000000000,
    ST_READY = 11'b10000000000
  } cirp_state_t;

  typedef enum logic [2:0] {
    BUS_NONE = 3'h0,
    BUS_RD_PTR = 3'h1,
    BUS_RD_SEG = 3'h2,
    BUS_PUSH_FL = 3'h3,
    BUS_PUSH_SEG = 3'h4,
    BUS_PUSH_PTR = 3'h5
  } cirp_bus_op_t;

  // one vectoring bus request
  typedef struct packed {
    cirp_bus_op_t op;
    logic [19:0] addr;
  } cirp_bus_req_t;

  // instruction-boundary report from the execution unit
  typedef struct packed {
    logic boundary;
    logic seg_load;
    logic wait_insn;
    logic numeric_busy;
    logic string_iter;
    logic exc_valid;
    logic [7:0] exc_type;
  } cirp_boundary_t;

  // vector entry byte address: type times four
  function automatic logic [19:0] vec_addr(input logic [7:0] vtype, input logic second);
    vec_addr = VEC_TABLE_BASE + {10'h000, vtype, 2'b00} + (second ? 20'h00002 : 20'h00000);
  endfunction
endpackage

//--- hdl/cirp_core.sv
// interrupt and exception recognition, priority and vectoring sequence
// Behaviour
// - interrupts are taken only at instruction boundaries
// - longest instruction is 69 clocks, bounding recognition delay
// - maskable request ignored while interrupt enable is clear
// - no interrupt recognised while the bus is held by another master
// - no recognition during an established coprocessor numerics transfer
// - segment register load holds off recognition through the next instruction
// - string repeats interruptible between iterations; only last prefix restored
// - wait instruction interruptible, return points back to the wait
// - self-typed vectoring runs fixed ten-step sequence of 42 clocks
// - maskable vector type comes from the interrupt control unit
// - on-chip bus master may use idle slots, stretching the sequence
// - nonmaskable before maskable; maskable waits for enable and top priority
// - at most three vectors per boundary: exception, then nonmaskable, then single step
// - exception vectored first, nonmaskable vector immediately after
// - nonmaskable accepted at any valid boundary, even in exception handler
// - interrupt vectored first, single step immediately after
// - nonmaskable request generates type 2 with no external cycle
// - vectoring pushes flags, clears step and enable, pushes segment and pointer
// - vector table spans 0H to 3FFH, two even words read per entry
// - single step vectoring clears step flag; return restores it
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
module cirp_core
  import cirp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_pin,
  input wire logic mask_req,
  input wire logic [7:0] mask_type,
  output logic mask_ack,
  input wire cirp_pkg::cirp_boundary_t bnd,
  input wire logic bus_held,
  input wire logic return_from_interrupt,
  input wire logic [15:0] saved_flags,
  input wire logic bus_slot_busy,
  output cirp_pkg::cirp_bus_req_t bus_req,
  output logic [15:0] flags_out,
  output logic vector_active,
  output logic [7:0] vector_type,
  output logic handler_go
);
  import cirp_pkg::*;

  // address bits must cover the map and fit the 8-bit offsets
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_addr_w_check
    $error("ADDR_W must lie between 4 and 8");
  end

  // nmi pin synchroniser, three stages
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q, nmi_lvl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_s1_q <= 1'b0;
      nmi_s2_q <= 1'b0;
      nmi_s3_q <= 1'b0;
      nmi_lvl_q <= 1'b0;
    end else begin
      nmi_s1_q <= nmi_pin;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
      if (nmi_s2_q == nmi_s3_q) begin
        nmi_lvl_q <= nmi_s3_q;
      end
    end
  end
  // rising edge once the last two stages agree
  logic nmi_edge;
  assign nmi_edge = nmi_s2_q && nmi_s3_q && !nmi_lvl_q;

  // state and registers
  cirp_state_t state_q;
  logic [3:0] step_cnt_q;
  logic [15:0] flags_q;
  logic nmi_pend_q, step_pend_q, nmi_chain_q, step_chain_q, seg_hold_q;
  logic [7:0] cur_type_q;
  logic [15:0] vec_count_q;
  logic [7:0] last_mask_type_q;
  logic aw_hit_ctrl;
  // last clock of a vector, not stalled by an on-chip master
  logic seq_end;
  assign seq_end = state_q == ST_IDLE4 && step_cnt_q == 4'h1 && !bus_slot_busy;

  // recognition gating
  logic boundary_ok, take_exc, take_nmi, take_mask, take_step, idle_fsm;
  logic step_trap, step_any;
  assign idle_fsm = state_q == ST_READY;
  // a segment load keeps its own boundary closed, the next one opens
  assign boundary_ok = bnd.boundary && !bus_held && !bnd.numeric_busy && !bnd.seg_load
                       && idle_fsm;
  // trap due after an instruction run with the step flag set
  assign step_trap = bnd.boundary && flags_q[FLAG_STEP_BIT] && !bnd.seg_load && !bnd.wait_insn
                     && idle_fsm;
  assign step_any = step_pend_q || step_trap;
  assign take_exc = boundary_ok && bnd.exc_valid;
  assign take_nmi = boundary_ok && !bnd.exc_valid && (nmi_pend_q || nmi_chain_q);
  assign take_mask = boundary_ok && !bnd.exc_valid && !nmi_pend_q && !nmi_chain_q
                     && mask_req && flags_q[FLAG_IE_BIT];
  assign take_step = boundary_ok && !bnd.exc_valid && !nmi_pend_q && !nmi_chain_q
                     && !take_mask && step_any;
  logic start_vec;
  assign start_vec = take_exc || take_nmi || take_mask || take_step;

  // segment load seen on the last boundary, for status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_hold_q <= 1'b0;
    end else if (bnd.boundary) begin
      seg_hold_q <= bnd.seg_load;
    end
  end

  // nmi pending latch: edge sets, acceptance clears, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_q <= 1'b1;
    end else if (take_nmi || (take_exc && nmi_pend_q)) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // chained vectors taken right after the current one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_chain_q <= 1'b0;
      step_chain_q <= 1'b0;
    end else begin
      if (take_exc && nmi_pend_q) begin
        nmi_chain_q <= 1'b1;
      end else if (seq_end && cur_type_q == VEC_NMI) begin
        nmi_chain_q <= 1'b0;
      end
      if ((take_exc || take_nmi || take_mask) && step_any) begin
        step_chain_q <= 1'b1;
      end else if (seq_end && cur_type_q == VEC_STEP) begin
        step_chain_q <= 1'b0;
      end
    end
  end

  // single step trap pending after an instruction run with the step flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_pend_q <= 1'b0;
    end else if (step_trap && !start_vec) begin
      step_pend_q <= 1'b1;
    end else if (start_vec) begin
      step_pend_q <= 1'b0;
    end
  end

  // status word: vectoring clears step and enable, return restores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 16'h0000;
    end else if (state_q == ST_PUSH_FL && step_cnt_q == 4'h1) begin
      flags_q[FLAG_STEP_BIT] <= 1'b0;
      flags_q[FLAG_IE_BIT] <= 1'b0;
    end else if (return_from_interrupt) begin
      flags_q <= saved_flags;
    end else if (aw_hit_ctrl) begin
      flags_q[FLAG_IE_BIT] <= s_axi_wdata[CTRL_IE_BIT];
      flags_q[FLAG_STEP_BIT] <= s_axi_wdata[CTRL_STEP_BIT];
    end
  end

  // vector type capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_type_q <= VEC_DIVIDE;
      last_mask_type_q <= 8'h00;
    end else if (take_exc) begin
      cur_type_q <= bnd.exc_type;
    end else if (take_nmi) begin
      cur_type_q <= VEC_NMI;
    end else if (take_mask) begin
      cur_type_q <= mask_type;
      last_mask_type_q <= mask_type;
    end else if (take_step) begin
      cur_type_q <= VEC_STEP;
    end else if (seq_end) begin
      if (nmi_chain_q && cur_type_q != VEC_NMI) begin
        cur_type_q <= VEC_NMI;
      end else if (step_chain_q && cur_type_q != VEC_STEP) begin
        cur_type_q <= VEC_STEP;
      end
    end
  end

  // vectoring sequence state machine
  function automatic logic [3:0] len_of(input cirp_state_t s);
    case (s)
      ST_IDLE0: len_of = LEN_IDLE0;
      ST_RD_PTR: len_of = LEN_RD_PTR;
      ST_IDLE1: len_of = LEN_IDLE1;
      ST_RD_SEG: len_of = LEN_RD_SEG;
      ST_IDLE2: len_of = LEN_IDLE2;
      ST_PUSH_FL: len_of = LEN_PUSH_FL;
      ST_IDLE3: len_of = LEN_IDLE3;
      ST_PUSH_SEG: len_of = LEN_PUSH_SEG;
      ST_PUSH_PTR: len_of = LEN_PUSH_PTR;
      ST_IDLE4: len_of = LEN_IDLE4;
      default: len_of = 4'h1;
    endcase
  endfunction

  logic is_idle_slot;
  assign is_idle_slot = state_q == ST_IDLE0 || state_q == ST_IDLE1 || state_q == ST_IDLE2
                        || state_q == ST_IDLE3 || state_q == ST_IDLE4;
  logic chain_more;
  assign chain_more = (nmi_chain_q && cur_type_q != VEC_NMI)
                      || (step_chain_q && cur_type_q != VEC_STEP);

  cirp_state_t next_state;
  always_comb begin
    case (state_q)
      ST_IDLE0: next_state = ST_RD_PTR;
      ST_RD_PTR: next_state = ST_IDLE1;
      ST_IDLE1: next_state = ST_RD_SEG;
      ST_RD_SEG: next_state = ST_IDLE2;
      ST_IDLE2: next_state = ST_PUSH_FL;
      ST_PUSH_FL: next_state = ST_IDLE3;
      ST_IDLE3: next_state = ST_PUSH_SEG;
      ST_PUSH_SEG: next_state = ST_PUSH_PTR;
      ST_PUSH_PTR: next_state = ST_IDLE4;
      ST_IDLE4: next_state = chain_more ? ST_IDLE0 : ST_READY;
      default: next_state = ST_READY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_READY;
      step_cnt_q <= 4'h1;
    end else if (state_q == ST_READY) begin
      if (start_vec) begin
        state_q <= ST_IDLE0;
        step_cnt_q <= LEN_IDLE0;
      end
    end else if (is_idle_slot && bus_slot_busy) begin
      step_cnt_q <= step_cnt_q;
    end else if (step_cnt_q == 4'h1) begin
      state_q <= next_state;
      step_cnt_q <= len_of(next_state);
    end else begin
      step_cnt_q <= step_cnt_q - 4'h1;
    end
  end

  // bus requests of the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_req <= '{op: BUS_NONE, addr: 20'h00000};
    end else begin
      case (state_q)
        ST_RD_PTR: bus_req <= '{op: BUS_RD_PTR, addr: vec_addr(cur_type_q, 1'b0)};
        ST_RD_SEG: bus_req <= '{op: BUS_RD_SEG, addr: vec_addr(cur_type_q, 1'b1)};
        ST_PUSH_FL: bus_req <= '{op: BUS_PUSH_FL, addr: 20'h00000};
        ST_PUSH_SEG: bus_req <= '{op: BUS_PUSH_SEG, addr: 20'h00000};
        ST_PUSH_PTR: bus_req <= '{op: BUS_PUSH_PTR, addr: 20'h00000};
        default: bus_req <= '{op: BUS_NONE, addr: 20'h00000};
      endcase
    end
  end

  // handshake and status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ack <= 1'b0;
      vector_active <= 1'b0;
      vector_type <= 8'h00;
      handler_go <= 1'b0;
      flags_out <= 16'h0000;
      vec_count_q <= 16'h0000;
    end else begin
      mask_ack <= take_mask;
      vector_active <= !idle_fsm;
      vector_type <= cur_type_q;
      handler_go <= seq_end && !chain_more;
      flags_out <= flags_q;
      if (seq_end) begin
        vec_count_q <= vec_count_q + 16'h0001;
      end
    end
  end

  // axi4-lite slave: write, readies for one cycle, response after both are taken
  logic wr_offer;
  logic wr_take;
  assign wr_offer = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  assign aw_hit_ctrl = wr_take && s_axi_awaddr == ADDR_CTRL[ADDR_W-1:0] && s_axi_wstrb[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_offer;
      s_axi_wready <= wr_offer;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= s_axi_awaddr == ADDR_CTRL[ADDR_W-1:0] ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite slave: read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL[ADDR_W-1:0]: s_axi_rdata <= {30'h0, flags_q[FLAG_STEP_BIT], flags_q[FLAG_IE_BIT]};
          ADDR_STATUS[ADDR_W-1:0]: s_axi_rdata <= {16'h0, state_q == ST_READY, 2'b00,
                                     nmi_pend_q, step_pend_q, nmi_chain_q, step_chain_q,
                                     seg_hold_q, cur_type_q};
          ADDR_VEC[ADDR_W-1:0]: s_axi_rdata <= {24'h0, last_mask_type_q};
          ADDR_COUNT[ADDR_W-1:0]: s_axi_rdata <= {16'h0, vec_count_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cirp_core

//--- sim/cirp_properties.sv
// concurrent checks on the ports of the recognition and vectoring unit
module cirp_properties
  import cirp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cirp_pkg::cirp_boundary_t bnd,
  input wire logic bus_held,
  input wire logic mask_req,
  input wire logic mask_ack,
  input wire cirp_pkg::cirp_bus_req_t bus_req,
  input wire logic [15:0] flags_out,
  input wire logic vector_active,
  input wire logic [7:0] vector_type,
  input wire logic handler_go
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_hold_blocks: assert property (
    bnd.boundary && bus_held && !vector_active && !$past(bnd.boundary) |-> ##2 !vector_active)
    else $error("vector started while bus held");
  chk_numeric_blocks: assert property (
    bnd.boundary && bnd.numeric_busy && !vector_active && !$past(bnd.boundary)
    |-> ##2 !vector_active)
    else $error("vector started during numerics transfer");
  chk_seg_blocks: assert property (
    bnd.boundary && bnd.seg_load && !vector_active && !$past(bnd.boundary)
    |-> ##2 !vector_active)
    else $error("vector started on a segment load boundary");
  chk_mask_gated: assert property (
    bnd.boundary && !vector_active && !$past(bnd.boundary) ##1 !flags_out[FLAG_IE_BIT]
    |-> !mask_ack)
    else $error("maskable taken with enable clear");
  chk_ack_follows_req: assert property (
    mask_ack |-> $past(mask_req) ##1 !mask_ack)
    else $error("acknowledge without request or too long");
  chk_ptr_read_len: assert property (
    $rose(bus_req.op == BUS_RD_PTR) |-> (bus_req.op == BUS_RD_PTR)[*4] ##1 bus_req.op == BUS_NONE)
    else $error("pointer read step not four clocks");
  chk_push_order: assert property (
    $fell(bus_req.op == BUS_PUSH_SEG) |-> bus_req.op == BUS_PUSH_PTR)
    else $error("pointer push does not follow segment push");
  chk_ptr_addr: assert property (
    bus_req.op == BUS_RD_PTR |-> bus_req.addr == {10'h000, vector_type, 2'b00})
    else $error("pointer word address wrong");
  chk_seg_addr: assert property (
    bus_req.op == BUS_RD_SEG |-> bus_req.addr == {10'h000, vector_type, 2'b10})
    else $error("segment word address wrong");
  chk_flags_cleared: assert property (
    bus_req.op == BUS_PUSH_SEG |-> !flags_out[FLAG_STEP_BIT] && !flags_out[FLAG_IE_BIT])
    else $error("step or enable not cleared while vectoring");
  chk_go_pulse: assert property (
    handler_go |-> $past(vector_active) ##1 !handler_go)
    else $error("handler start pulse malformed");
  cover property (handler_go);
  cover property (mask_ack);
  cover property (bus_req.op == BUS_RD_PTR && vector_type == VEC_STEP);
endmodule // cirp_properties

bind cirp_core cirp_properties u_cirp_properties (.aclk, .aresetn, .bnd, .bus_held, .mask_req,
  .mask_ack, .bus_req, .flags_out, .vector_active, .vector_type, .handler_go);

//--- sim/cirp_icu_model.sv
// interrupt control unit model: holds a typed maskable request until acknowledged
module cirp_icu_model
  import cirp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raise,
  input wire logic [7:0] raise_type,
  input wire logic mask_ack,
  output logic mask_req,
  output logic [7:0] mask_type
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q;
  logic [7:0] type_q;
  logic [7:0] junk_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
      type_q <= 8'h00;
    end else if (raise) begin
      req_q <= 1'b1;
      type_q <= raise_type;
    end else if (mask_ack) begin
      req_q <= 1'b0;
    end
  end
  // type lines carry no meaning outside a request
  always_ff @(posedge aclk) begin
    junk_q <= !aresetn ? 8'hA5 : junk_q + 8'h5B;
  end
  assign mask_req = req_q;
  assign mask_type = req_q ? type_q : junk_q;
endmodule // cirp_icu_model

//--- sim/testbench.sv
// self-checking bench for the recognition, priority and vectoring unit
module testbench
  import cirp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, raise_type, mask_type, vector_type;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic nmi_pin, raise, bus_held, return_from_interrupt, bus_slot_busy, mask_req, mask_ack;
  logic vector_active, handler_go;
  logic [15:0] saved_flags, flags_out;
  cirp_boundary_t bnd;
  cirp_bus_req_t bus_req;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ack_n = 0;
  int act_n;
  int op_n[8];
  logic [7:0] seen_q[$];
  always #12.5 aclk = ~aclk;
  cirp_core u_cirp_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .nmi_pin, .mask_req, .mask_type, .mask_ack, .bnd, .bus_held,
    .return_from_interrupt, .saved_flags, .bus_slot_busy, .bus_req, .flags_out,
    .vector_active, .vector_type, .handler_go);
  cirp_icu_model u_cirp_icu_model (.aclk, .aresetn, .raise, .raise_type, .mask_ack,
    .mask_req, .mask_type);
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (mask_ack === 1'b1) ack_n++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, exp);
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
  // f = {seg_load, wait_insn, numeric_busy, string_iter, exc_valid}
  task automatic boundary(input logic [4:0] f, input logic [7:0] t);
    bnd <= cirp_boundary_t'({1'b1, f, t});
    @(posedge aclk);
    bnd <= '0;
  endtask
  task automatic ask(input logic [7:0] t);
    raise <= 1'b1;
    raise_type <= t;
    @(posedge aclk);
    raise <= 1'b0;
  endtask
  task automatic pulse_nmi();
    nmi_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    nmi_pin <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic quiet(input string what);
    int n;
    n = 0;
    repeat (60) begin
      @(posedge aclk);
      if (vector_active !== 1'b0) n++;
    end
    check(what, n, 0);
  endtask
  // follows one vectoring run, chained vectors included, until the handler starts
  task automatic watch(input int nvec, input logic stalled);
    int n;
    cirp_bus_op_t prev;
    seen_q = {};
    act_n = 0;
    op_n = '{default: 0};
    n = 0;
    prev = BUS_NONE;
    while (handler_go !== 1'b1 && n < 600) begin
      @(posedge aclk);
      n++;
      bus_slot_busy <= stalled && n < 8;
      if (vector_active === 1'b1) act_n++;
      op_n[bus_req.op]++;
      if (bus_req.op == BUS_RD_PTR && prev != BUS_RD_PTR) seen_q.push_back(vector_type);
      prev = bus_req.op;
    end
    check("handler_go", handler_go, 1'b1);
    for (int k = 1; k <= 5; k++) check("bus_op_len", op_n[k], 4 * nvec);
    if (nvec == 1 && !stalled) check("vector_len", act_n, VECTOR_TOTAL_CLOCKS);
    if (stalled) check("stall_len", act_n > VECTOR_TOTAL_CLOCKS, 1'b1);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ADDR_CTRL, d, r);
    check("ctrl_reset", d, CTRL_RESET);
    axi_rd(8'h10, d, r);
    check("unmapped_rresp", r, RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
    check("ie_after_reset", flags_out[FLAG_IE_BIT], 1'b0);
  endtask
  task automatic t_block();
    logic [31:0] d;
    logic [1:0] r;
    ask(8'h41);
    quiet("no_boundary");
    boundary(5'b00000, 8'h00);
    quiet("ie_clear");
    axi_wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    check("ie_set", flags_out[FLAG_IE_BIT], 1'b1);
    bus_held <= 1'b1;
    boundary(5'b00000, 8'h00);
    quiet("bus_held");
    bus_held <= 1'b0;
    boundary(5'b00100, 8'h00);
    quiet("numeric_busy");
    boundary(5'b10000, 8'h00);
    quiet("seg_load");
    boundary(5'b10000, 8'h00);
    quiet("seg_load_again");
    boundary(5'b00010, 8'h00);
    watch(1, 1'b0);
    check("mask_type", seen_q[0], 8'h41);
    check("mask_ack", ack_n, 1);
    check("ie_cleared", flags_out[FLAG_IE_BIT], 1'b0);
    axi_rd(ADDR_VEC, d, r);
    check("last_mask_type", d[7:0], 8'h41);
  endtask
  task automatic t_nmi();
    axi_wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    ask(8'h42);
    pulse_nmi();
    bus_slot_busy <= 1'b1;
    boundary(5'b01000, 8'h00);
    watch(1, 1'b1);
    check("nmi_first", seen_q[0], VEC_NMI);
    check("nmi_alone", seen_q.size(), 1);
    check("nmi_no_ack", ack_n, 1);
    boundary(5'b00000, 8'h00);
    quiet("mask_waits");
    axi_wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    boundary(5'b00000, 8'h00);
    watch(1, 1'b0);
    check("mask_later", seen_q[0], 8'h42);
  endtask
  task automatic t_exc();
    pulse_nmi();
    boundary(5'b00001, VEC_DIVIDE);
    watch(2, 1'b0);
    check("exc_count", seen_q.size(), 2);
    check("exc_first", seen_q[0], VEC_DIVIDE);
    check("nmi_chained", seen_q[1], VEC_NMI);
  endtask
  task automatic t_step();
    axi_wr(ADDR_CTRL, 32'h00000002, RESP_OKAY);
    check("step_set", flags_out[FLAG_STEP_BIT], 1'b1);
    pulse_nmi();
    boundary(5'b00000, 8'h00);
    watch(2, 1'b0);
    check("int_first", seen_q[0], VEC_NMI);
    check("step_next", seen_q[1], VEC_STEP);
    check("step_cleared", flags_out[FLAG_STEP_BIT], 1'b0);
    saved_flags <= 16'h0100;
    return_from_interrupt <= 1'b1;
    @(posedge aclk);
    return_from_interrupt <= 1'b0;
    repeat (2) @(posedge aclk);
    check("step_restored", flags_out[FLAG_STEP_BIT], 1'b1);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, raise_type, saved_flags} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {nmi_pin, raise, bus_held, return_from_interrupt, bus_slot_busy} = '0;
    s_axi_wstrb = 4'hF;
    bnd = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_block();
    t_nmi();
    t_exc();
    t_step();
    print_verdict();
  end
endmodule // testbench
